// ### src/gain_control.sv
// Global analog and digital gain control with pixel stream gain stage
`timescale 1ns/1ps

// Behaviour
// - The analog gain register resets to 0x03, bits 6:3 coarse, 2:0 fine.
// - Coarse/fine codes go to the analog chain; 0000/011 is x1, 1010/111 x72.
// - The digital gain register resets to 0x00, bits 7:5 power, 4:0 fraction.
// - Each pixel is multiplied by power stage times (1 + fraction/32).
// - Power codes 000..011 give x1,x2,x4,x8 and any code with bit 7 set x16.
// - The fraction stage steps by 1/32, from x1.00 at 0 to about x1.97.
module gain_control
#(
   parameter int PIX_W = 10
)
(
   // Clock and reset
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   // Register port
   input  wire logic [15:0]      reg_addr_i,
   input  wire logic [7:0]       reg_wdata_i,
   input  wire logic             reg_wr_i,
   input  wire logic             reg_rd_i,
   output logic [7:0]            reg_rdata_o,
   output logic                  reg_rvalid_o,
   // Analog chain codes
   output logic [3:0]            coarse_gain_o,
   output logic [2:0]            fine_gain_o,
   output logic [16:0]           analog_gain_milli_o,
   output logic                  analog_code_bad_o,
   // Pixel stream from readout
   input  wire logic             pix_valid_i,
   input  wire logic [PIX_W-1:0] pix_data_i,
   // Pixel stream to image processing
   output logic                  pix_valid_o,
   output logic [PIX_W-1:0]      pix_data_o
);

   logic [6:0]  analog_r;
   logic [6:0]  analog_nxt;
   logic [7:0]  digital_r;
   logic [7:0]  digital_nxt;
   logic [7:0]  rdata_r;
   logic [7:0]  rdata_nxt;
   logic        rvalid_r;
   logic        rvalid_nxt;
   logic [16:0] milli_r;
   logic [16:0] milli_nxt;
   logic        bad_r;
   logic        bad_nxt;
   logic [16:0] row_milli;
   logic [20:0] fine_prod;
   logic [3:0]  coarse_code;
   logic [2:0]  fine_code;

   ////////////////////////////////////////////////////////////////////////
   // Row gain at the unity fine code, zero for undefined coarse codes
   function automatic logic [16:0] row_gain(input logic [3:0] coarse);
      case (coarse)
         4'h0:    row_gain = gain_pkg::ROW_MILLI_0;
         4'h1:    row_gain = gain_pkg::ROW_MILLI_1;
         4'h2:    row_gain = gain_pkg::ROW_MILLI_2;
         4'h3:    row_gain = gain_pkg::ROW_MILLI_3;
         4'h4:    row_gain = gain_pkg::ROW_MILLI_4;
         4'h5:    row_gain = gain_pkg::ROW_MILLI_5;
         4'h6:    row_gain = gain_pkg::ROW_MILLI_6;
         4'h7:    row_gain = gain_pkg::ROW_MILLI_7;
         4'h8:    row_gain = gain_pkg::ROW_MILLI_8;
         4'h9:    row_gain = gain_pkg::ROW_MILLI_9;
         4'hA:    row_gain = gain_pkg::ROW_MILLI_10;
         default: row_gain = 17'h00000;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register writes and reads; bit 7 of the analog register is reserved
   always_comb
   begin
      analog_nxt  = analog_r;
      digital_nxt = digital_r;
      rdata_nxt   = rdata_r;
      rvalid_nxt  = reg_rd_i;
      if (reg_wr_i && reg_addr_i == gain_pkg::ANALOG_GAIN_ADDR)
         analog_nxt = reg_wdata_i[6:0];
      if (reg_wr_i && reg_addr_i == gain_pkg::DIGITAL_GAIN_ADDR)
         digital_nxt = reg_wdata_i;
      if (reg_rd_i)
      begin
         // Unmapped offsets read as zero
         case (reg_addr_i)
            gain_pkg::ANALOG_GAIN_ADDR:  rdata_nxt = {1'b0, analog_r};
            gain_pkg::DIGITAL_GAIN_ADDR: rdata_nxt = digital_r;
            default:                     rdata_nxt = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Field split of the analog register, shared by decode and outputs
   assign coarse_code = analog_r[gain_pkg::COARSE_MSB:gain_pkg::COARSE_LSB];
   assign fine_code   = analog_r[gain_pkg::FINE_MSB:gain_pkg::FINE_LSB];

   // Combined analog gain in thousandths, for monitoring and the chain
   always_comb
   begin
      row_milli = row_gain(coarse_code);
      fine_prod = 21'(row_milli) * 21'(gain_pkg::FINE_BIAS
                  + 4'(fine_code));
      milli_nxt = 17'(fine_prod >> gain_pkg::FINE_SHIFT);
      // Codes above the top row have no defined gain
      bad_nxt   = coarse_code > gain_pkg::COARSE_MAX;
   end

   // State registers
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         analog_r  <= gain_pkg::ANALOG_GAIN_RST[6:0];
         digital_r <= gain_pkg::DIGITAL_GAIN_RST;
         rdata_r   <= 8'h00;
         rvalid_r  <= 1'b0;
         milli_r   <= 17'h00000;
         bad_r     <= 1'b0;
      end
      else
      begin
         analog_r  <= analog_nxt;
         digital_r <= digital_nxt;
         rdata_r   <= rdata_nxt;
         rvalid_r  <= rvalid_nxt;
         milli_r   <= milli_nxt;
         bad_r     <= bad_nxt;
      end
   end

   // Codes leave straight from the register so the chain sees no glitches
   assign coarse_gain_o       = coarse_code;
   assign fine_gain_o         = fine_code;
   assign analog_gain_milli_o = milli_r;
   assign analog_code_bad_o   = bad_r;
   assign reg_rdata_o         = rdata_r;
   assign reg_rvalid_o        = rvalid_r;

   ////////////////////////////////////////////////////////////////////////
   // Digital gain stage; a new setting applies from the next pixel taken
   pixel_gain_mult
   #(
      .PIX_W  (PIX_W),
      .FRAC_W (5)
   )
   u_mult
   (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .pow_code_i  (digital_r[gain_pkg::POW_MSB:gain_pkg::POW_LSB]),
      .frac_code_i (digital_r[gain_pkg::FRAC_MSB:gain_pkg::FRAC_LSB]),
      .pix_valid_i (pix_valid_i),
      .pix_data_i  (pix_data_i),
      .pix_valid_o (pix_valid_o),
      .pix_data_o  (pix_data_o)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks
   // Reset checks look at the first edge after release only, so the
   // unknown state before the very first reset edge is never judged
   a_analog_reset_val: assert property (@(posedge mclk_i)
      $past(rst_i) && !rst_i |->
      {1'b0, coarse_gain_o, fine_gain_o} == gain_pkg::ANALOG_GAIN_RST)
      else $error("analog gain reset value wrong");
   a_digital_reset_val: assert property (@(posedge mclk_i)
      $past(rst_i) && !rst_i |-> digital_r == gain_pkg::DIGITAL_GAIN_RST &&
      reg_rdata_o == 8'h00 && pix_valid_o == 1'b0)
      else $error("reset outputs wrong");
   a_analog_write_back: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      reg_wr_i && reg_addr_i == gain_pkg::ANALOG_GAIN_ADDR ##1
      reg_rd_i && reg_addr_i == gain_pkg::ANALOG_GAIN_ADDR |=>
      reg_rvalid_o && reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h7F))
      else $error("analog register readback wrong");
   a_digital_write_back: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      reg_wr_i && reg_addr_i == gain_pkg::DIGITAL_GAIN_ADDR ##1
      reg_rd_i && reg_addr_i == gain_pkg::DIGITAL_GAIN_ADDR |=>
      reg_rvalid_o && reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("digital register readback wrong");
   a_unity_analog: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      coarse_gain_o == 4'h0 && fine_gain_o == gain_pkg::FINE_UNITY |=>
      analog_gain_milli_o == 17'h003E8)
      else $error("unity analog gain wrong");
   a_max_analog: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      coarse_gain_o == 4'hA && fine_gain_o == 3'h7 ##1
      coarse_gain_o == 4'hA && fine_gain_o == 3'h7 |->
      analog_gain_milli_o == 17'h11940)
      else $error("maximum analog gain wrong");
   a_bad_coarse_flag: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      coarse_gain_o > gain_pkg::COARSE_MAX |=>
      analog_code_bad_o && analog_gain_milli_o == 17'h00000)
      else $error("undefined coarse code not flagged");
   c_analog_write: cover property (@(posedge mclk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == 16'h5009);
   c_digital_max: cover property (@(posedge mclk_i) disable iff (rst_i)
      digital_r == 8'hFF && pix_valid_i);
   c_unmapped_read: cover property (@(posedge mclk_i) disable iff (rst_i)
      reg_rd_i && reg_addr_i == 16'h5008);

endmodule

// ### src/gain_pkg.sv
// Constants shared by the global gain control block
package gain_pkg;

   // Register offsets on the register port
   localparam logic [15:0] ANALOG_GAIN_ADDR  = 16'h5009;
   localparam logic [15:0] DIGITAL_GAIN_ADDR = 16'h500A;

   // Reset values
   localparam logic [7:0]  ANALOG_GAIN_RST   = 8'h03;
   localparam logic [7:0]  DIGITAL_GAIN_RST  = 8'h00;

   // Field positions of the analog gain register
   localparam int          COARSE_MSB        = 6;
   localparam int          COARSE_LSB        = 3;
   localparam int          FINE_MSB          = 2;
   localparam int          FINE_LSB          = 0;

   // Field positions of the digital gain register
   localparam int          POW_MSB           = 7;
   localparam int          POW_LSB           = 5;
   localparam int          FRAC_MSB          = 4;
   localparam int          FRAC_LSB          = 0;

   // Highest defined coarse code and fine code of unity
   localparam logic [3:0]  COARSE_MAX        = 4'hA;
   localparam logic [2:0]  FINE_UNITY        = 3'h3;

   // Analog gain in thousandths: row gain at unity fine code
   localparam int          MILLI_W           = 17;
   localparam logic [16:0] ROW_MILLI_0       = 17'h003E8;
   localparam logic [16:0] ROW_MILLI_1       = 17'h007D0;
   localparam logic [16:0] ROW_MILLI_2       = 17'h00BB8;
   localparam logic [16:0] ROW_MILLI_3       = 17'h00FA0;
   localparam logic [16:0] ROW_MILLI_4       = 17'h01388;
   localparam logic [16:0] ROW_MILLI_5       = 17'h01770;
   localparam logic [16:0] ROW_MILLI_6       = 17'h01B93;
   localparam logic [16:0] ROW_MILLI_7       = 17'h01F40;
   localparam logic [16:0] ROW_MILLI_8       = 17'h03E80;
   localparam logic [16:0] ROW_MILLI_9       = 17'h05DC0;
   localparam logic [16:0] ROW_MILLI_10      = 17'h0BB80;

   // Fine step: gain = row * (FINE_BIAS + fine) / 2^FINE_SHIFT
   localparam logic [3:0]  FINE_BIAS         = 4'h5;
   localparam int          FINE_SHIFT        = 3;

   // Digital gain: fraction denominator is 2^FRAC_SHIFT
   localparam int          FRAC_SHIFT        = 5;
   localparam logic [2:0]  POW_SHIFT_TOP     = 3'h4;

endpackage

// ### src/pixel_gain_mult.sv
// Digital gain stage: pixel times power-of-two times fraction, clipped
`timescale 1ns/1ps

module pixel_gain_mult
#(
   parameter int PIX_W  = 10,
   parameter int FRAC_W = 5
)
(
   // Clock and reset
   input  wire logic              mclk_i,
   input  wire logic              rst_i,
   // Gain setting
   input  wire logic [2:0]        pow_code_i,
   input  wire logic [FRAC_W-1:0] frac_code_i,
   // Pixel stream in
   input  wire logic              pix_valid_i,
   input  wire logic [PIX_W-1:0]  pix_data_i,
   // Pixel stream out
   output logic                   pix_valid_o,
   output logic [PIX_W-1:0]       pix_data_o
);

   localparam int MUL_W  = PIX_W + FRAC_W + 1;
   localparam int WIDE_W = MUL_W + 4;
   localparam logic [WIDE_W-1:0] PIX_MAX = WIDE_W'((1 << PIX_W) - 1);

   logic [2:0]        shift_amt;
   logic [MUL_W-1:0]  mult;
   logic [WIDE_W-1:0] wide;
   logic [PIX_W-1:0]  data_nxt;
   logic [PIX_W-1:0]  data_r;
   logic              valid_r;

   ////////////////////////////////////////////////////////////////////////
   // Power stage: top code bit forces x16, ignoring the low bits
   always_comb
   begin
      shift_amt = pow_code_i[2] ? gain_pkg::POW_SHIFT_TOP
                                : {1'b0, pow_code_i[1:0]};
      mult = MUL_W'(pix_data_i) * MUL_W'({1'b1, frac_code_i});
      wide = (WIDE_W'(mult) << shift_amt) >> gain_pkg::FRAC_SHIFT;
      // Saturate instead of wrapping so highlights stay white
      data_nxt = (wide > PIX_MAX) ? {PIX_W{1'b1}}
                                  : wide[PIX_W-1:0];
   end

   // Output register: one cycle of latency, data holds between pixels
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         valid_r <= 1'b0;
         data_r  <= '0;
      end
      else
      begin
         valid_r <= pix_valid_i;
         if (pix_valid_i)
            data_r <= data_nxt;
      end
   end

   assign pix_valid_o = valid_r;
   assign pix_data_o  = data_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_gain_product: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      pix_valid_i && !pow_code_i[2] |=> pix_valid_o &&
      (longint'(pix_data_o) == ((((longint'($past(pix_data_i))
         * (32 + longint'($past(frac_code_i))))
         << $past(pow_code_i[1:0])) >> 5) > 1023 ? 1023 :
       (((longint'($past(pix_data_i)) * (32 + longint'($past(frac_code_i))))
         << $past(pow_code_i[1:0])) >> 5))))
      else $error("digital gain product wrong");
   a_pow_top_x16: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      pix_valid_i && pow_code_i[2] && frac_code_i == '0 |=>
      longint'(pix_data_o) == ((longint'($past(pix_data_i)) * 16 > 1023)
         ? 1023 : longint'($past(pix_data_i)) * 16))
      else $error("top power code not x16");
   a_frac_unity: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      pix_valid_i && pow_code_i == 3'h0 && frac_code_i == '0 |=>
      pix_data_o == $past(pix_data_i))
      else $error("unity gain changed pixel");
   a_clip_max: assert property (@(posedge mclk_i) disable iff (rst_i)
      pix_valid_i && pix_data_i == {PIX_W{1'b1}} && frac_code_i != '0 |=>
      pix_data_o == {PIX_W{1'b1}})
      else $error("pixel wrapped instead of clipping");
   c_clip_seen: cover property (@(posedge mclk_i) disable iff (rst_i)
      pix_valid_i && wide > PIX_MAX);

endmodule

// ### tb/pixel_source.sv
// Behavioural readout chain that feeds pixels into the gain block
`timescale 1ns/1ps

module pixel_source
(
   // Clock
   input  wire logic       mclk_i,
   // Request from the bench
   input  wire logic       send_i,
   input  wire logic [9:0] value_i,
   // Pixel stream to the gain block
   output logic            pix_valid_o,
   output logic [9:0]      pix_data_o
);
   // Known idle levels before the first clock edge
   initial
   begin
      pix_valid_o = 1'b0;
      pix_data_o  = 10'h000;
   end

   // Idle data is inverted each cycle, so a design that takes data
   // without its qualifier shows up as a wrong pixel
   always @(posedge mclk_i)
   begin
      pix_valid_o <= send_i;
      pix_data_o  <= send_i ? value_i : ~pix_data_o;
   end
endmodule

// ### tb/tb_top.sv
// Self-checking testbench for the global gain control block
`timescale 1ns/1ps

module tb_top;
   logic        mclk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [15:0] reg_addr_i = 16'h0000;
   logic [7:0]  reg_wdata_i = 8'h00;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [7:0]  reg_rdata_o;
   logic        reg_rvalid_o;
   logic [3:0]  coarse_gain_o;
   logic [2:0]  fine_gain_o;
   logic [16:0] analog_gain_milli_o;
   logic        analog_code_bad_o;
   logic        pix_valid_i;
   logic [9:0]  pix_data_i;
   logic        pix_valid_o;
   logic [9:0]  pix_data_o;
   logic        send = 1'b0;
   logic [9:0]  send_val = 10'h000;
   int          error_cnt = 0;
   int          cmp_count = 0;
   logic [16:0] rows [11] = '{17'h003E8, 17'h007D0, 17'h00BB8, 17'h00FA0,
      17'h01388, 17'h01770, 17'h01B93, 17'h01F40, 17'h03E80, 17'h05DC0,
      17'h0BB80};
   logic [7:0]  g;

   ////////////////////////////////////////////////////////////////////
   // Clock at 25 ns
   initial
   begin
      forever #12.5 mclk_i = ~mclk_i;
   end

   gain_control #(.PIX_W(10)) uut (.mclk_i(mclk_i), .rst_i(rst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .reg_rvalid_o(reg_rvalid_o), .coarse_gain_o(coarse_gain_o),
      .fine_gain_o(fine_gain_o), .analog_gain_milli_o(analog_gain_milli_o),
      .analog_code_bad_o(analog_code_bad_o), .pix_valid_i(pix_valid_i),
      .pix_data_i(pix_data_i), .pix_valid_o(pix_valid_o),
      .pix_data_o(pix_data_o));

   pixel_source src (.mclk_i(mclk_i), .send_i(send), .value_i(send_val),
      .pix_valid_o(pix_valid_i), .pix_data_o(pix_data_i));

   ////////////////////////////////////////////////////////////////////
   // Compare and count; values are four-state so X never matches
   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Single verdict point, also reached by the watchdog
   task automatic give_verdict;
      if (error_cnt == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Register write: strobe held for exactly one sampling edge
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i    <= 1'b0;
   endtask

   // Register read: answer is due one cycle after the strobe edge
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i   <= 1'b0;
      #1;
      chk(reg_rvalid_o, 17'h1);
      chk(reg_rdata_o, exp);
      // The answer strobe must be a single-cycle pulse
      @(posedge mclk_i);
      #1;
      chk(reg_rvalid_o, 17'h0);
   endtask

   // Write, then read on the very next edge; the read sees the new value
   task automatic wrb(input logic [15:0] a, input logic [7:0] d,
                      input logic [7:0] exp);
      @(posedge mclk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i    <= 1'b0;
      reg_rd_i    <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i    <= 1'b0;
      #1;
      chk(reg_rvalid_o, 17'h1);
      chk(reg_rdata_o, exp);
   endtask

   // Analog code write, then fields, combined gain and range flag
   task automatic ana(input logic [3:0] c, input logic [2:0] f);
      wr(16'h5009, {1'b0, c, f});
      repeat (2) @(posedge mclk_i);
      #1;
      chk({coarse_gain_o, fine_gain_o}, {10'h0, c, f});
      chk(analog_gain_milli_o, (c > 4'hA) ? 17'h0 :
         17'((rows[c] * (5 + f)) >> 3));
      chk(analog_code_bad_o, c > 4'hA);
   endtask

   // Expected gained pixel: power stage, 1/32 fraction, clip at full scale
   function automatic logic [16:0] gp(input logic [9:0] p,
                                      input logic [7:0] gn);
      logic [31:0] v;
      v = ((p * (32 + gn[4:0])) << (gn[7] ? 4 : gn[6:5])) >> 5;
      return (v > 1023) ? 17'h003FF : v[16:0];
   endfunction

   // One pixel through the source model, checked one cycle after intake
   task automatic px(input logic [9:0] v);
      @(posedge mclk_i);
      send     <= 1'b1;
      send_val <= v;
      @(posedge mclk_i);
      send     <= 1'b0;
      @(posedge mclk_i);
      #1;
      chk(pix_valid_o, 17'h1);
      chk(pix_data_o, gp(v, g));
   endtask

   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      g = 8'h00;
      repeat (8) @(posedge mclk_i);
      rst_i <= 1'b0;
      rd(16'h5009, 8'h03);
      rd(16'h500A, 8'h00);
      chk({coarse_gain_o, fine_gain_o}, 17'h3);
      chk(analog_gain_milli_o, 17'h003E8);
      wrb(16'h5009, 8'hD7, 8'h57);
      rd(16'h5009, 8'h57);
      chk(analog_gain_milli_o, 17'h11940);
      for (int c = 0; c < 12; c++)
         ana(c[3:0], c[2:0]);
      ana(4'h6, 3'h0);
      wr(16'h5008, 8'hFF);
      rd(16'h5008, 8'h00);
      rd(16'h5009, 8'h30);
      // Every power code with a spread of fractions, small and clipping
      for (int k = 0; k < 8; k++)
      begin
         g = {k[2:0], 5'(k * 4 + 3)};
         wrb(16'h500A, g, g);
         rd(16'h500A, g);
         px(10'd37);
         px(10'd1000);
      end
      g = 8'h1F;
      wr(16'h500A, g);
      px(10'd500);
      px(10'd1023);
      g = 8'h80;
      wr(16'h500A, g);
      px(10'd50);
      // Mid-run reset must bring both registers back to their defaults
      @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      rd(16'h5009, 8'h03);
      rd(16'h500A, 8'h00);
      g = 8'h00;
      wr(16'h500A, g);
      px(10'd1023);
      repeat (2) @(posedge mclk_i);
      #1;
      chk(pix_valid_o, 17'h0);
      give_verdict;
   end

   // Watchdog well beyond the roughly 200 cycles the run needs
   initial
   begin
      #(25 * 20000);
      error_cnt++;
      give_verdict;
   end
endmodule
